// ===== design/acr_top.sv
/*
 Converter control and result block: register file on AHB-Lite,
 conversion clock divider, reference select, auto-trigger edge detect,
 conversion sequencer and result justification, done interrupt.
 Assumes an analog core outside that delivers a 10-bit sample on
 sample_in, stable whenever a conversion finishes, and trigger sources
 from other clock domains or pins, which are synchronised here.
*/
// What this block does
// - Right format zeroes six high result bits
// - Left format zeroes six low result bits
// - Left: high holds 9..2, low 7..6 hold 1..0
// - Right: high 1..0 hold 9..8, low 7..0
// - Clock select field picks divider or RC
// - Negative reference bit picks ground or pin
// - Disabled converter disconnects all multiplexer inputs
// - Positive reference field picks supply, pin, fixed
// - Trigger codes select timer sources
// - Trigger codes select comparators, cells, captures
// - Zero trigger code starts nothing
// - Triggers act on rising edge only
// - Timer triggers taken when flag sets
// - Unimplemented config and trigger bits read zero, ignore writes; control bits 7:2 are stored
// - Config and trigger reset zero; results kept
// - Status bit starts, holds, self-clears
// - Enable bit turns converter on
`timescale 1ns/1ns
module acr_top
   import acr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [ACR_TRG_SRCS-1:0] trig_src,
   input wire logic [ACR_RES_W-1:0] sample_in,
   output logic conv_clk_en,
   output logic rc_osc_en,
   output logic [2:0] pref_switch,
   output logic [1:0] nref_switch,
   output logic chan_mux_en,
   output logic converter_enable,
   output logic sample_hold,
   output logic irq
);

   // ***************************************************************
   // Registers
   // ***************************************************************
   logic [7:0] ctrl_q;
   logic [7:0] cfg_q;
   logic [7:0] trig_q;
   logic [7:0] resh_q;
   logic [7:0] resl_q;
   logic [7:0] irq_stat_q;
   logic [7:0] irq_mask_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   acr_state_e state_q;
   logic [7:0] div_q;
   logic [3:0] tad_cnt_q;
   logic [ACR_TRG_SRCS-1:0] s1_q, s2_q, s3_q;
   logic trig_prev_q;

   // Justification, shared by the load path
   // Both formats keep all ten bits; only their place moves.
   function automatic logic [15:0] justify(input logic right,
                                           input logic [9:0] r);
      if (right) begin
         justify = {6'h00, r[9:8], r[7:0]};
      end else begin
         justify = {r[9:2], r[1:0], 6'h00};
      end
   endfunction

   // Clock select code to divide ratio zero means RC oscillator
   // Codes 011 and 111 fall to the default, the RC path.
   function automatic logic [7:0] div_ratio(input logic [2:0] cs);
      case (cs)
         ACR_CS_DIV2: div_ratio = 8'h02;
         ACR_CS_DIV8: div_ratio = 8'h08;
         ACR_CS_DIV32: div_ratio = 8'h20;
         ACR_CS_DIV4: div_ratio = 8'h04;
         ACR_CS_DIV16: div_ratio = 8'h10;
         ACR_CS_DIV64: div_ratio = 8'h40;
         default: div_ratio = 8'h00;
      endcase
   endfunction

   // ***************************************************************
   // Bus decode
   // ***************************************************************
   // Only the low address byte is decoded; higher bits alias.
   wire addr_ok = hsel && hready && htrans[1];
   wire wr_req = addr_ok && hwrite;
   wire rd_req = addr_ok && !hwrite;
   wire [7:0] rd_addr = haddr[7:0];
   wire [7:0] wbyte = hwdata[7:0];
   wire wr_ctrl = wr_pend_q && (wr_addr_q == ACR_OFS_CTRL);
   wire wr_cfg = wr_pend_q && (wr_addr_q == ACR_OFS_CFG);
   wire wr_trig = wr_pend_q && (wr_addr_q == ACR_OFS_TRIG);
   wire wr_resh = wr_pend_q && (wr_addr_q == ACR_OFS_RESH);
   wire wr_resl = wr_pend_q && (wr_addr_q == ACR_OFS_RESL);
   wire wr_stat = wr_pend_q && (wr_addr_q == ACR_OFS_IRQ_STAT);
   wire wr_mask = wr_pend_q && (wr_addr_q == ACR_OFS_IRQ_MASK);

   // Fields
   // Control bits 7:2 are plain storage; they select nothing.
   wire en = ctrl_q[ACR_CTRL_EN_BIT];
   wire go = ctrl_q[ACR_CTRL_GO_BIT];
   wire fmt_right = cfg_q[ACR_CFG_FMT_BIT];
   wire [2:0] cs = cfg_q[ACR_CFG_CS_LSB +: 3];
   wire nref = cfg_q[ACR_CFG_NREF_BIT];
   wire [1:0] pref = cfg_q[ACR_CFG_PREF_LSB +: 2];
   wire [4:0] trg_code = trig_q[4:0];

   // ***************************************************************
   // Trigger select and edge detect
   // ***************************************************************
   // Timer sources are their interrupt-flag set pulses, so the rising
   // edge of the flag is the event.
   // The source index is the trigger code itself, so timers,
   // comparators, cells and captures need no decode table.
   // The range test comes first: a code past the vector would
   // otherwise feed an unknown bit into the edge detector.
   wire trig_sel = (trg_code != ACR_TRG_NONE) &&
      (32'(trg_code) < ACR_TRG_SRCS) && s3_q[trg_code] && s2_q[trg_code];
   wire trig_lvl = (32'(trg_code) < ACR_TRG_SRCS) && s2_q[trg_code];
   // Only a low-to-high move on the chosen source counts.
   wire trig_edge = trig_sel && !trig_prev_q;
   // A trigger while a conversion runs is dropped, and so is one that
   // meets a control write, which may clear the enable that cycle.
   // Selecting a source that already stands high counts as an edge.
   wire trig_start = trig_edge && en && (state_q == ACR_IDLE) &&
      !wr_ctrl;

   // ***************************************************************
   // Conversion clock enable
   // ***************************************************************
   // One tick per conversion clock period: an enable, never a clock,
   // so the whole block stays on hclk.
   wire [7:0] ratio = div_ratio(cs);
   wire use_rc = (cs == ACR_CS_RC_A) || (cs == ACR_CS_RC_B);
   wire [7:0] div_top = use_rc ? ACR_RC_DIV : ratio;
   wire tad_tick = en && (div_q == div_top - 8'h01);

   // Software start needs enable and status in the same write.
   wire sw_go = wr_ctrl && wbyte[ACR_CTRL_GO_BIT] && wbyte[ACR_CTRL_EN_BIT];
   // The eleventh tick ends the run; the load follows next cycle.
   wire conv_done = (state_q == ACR_CONV) && tad_tick &&
      (tad_cnt_q == 4'(ACR_CONV_TADS - 1));
   // The core must hold the sample steady at the load edge.
   wire [15:0] just = justify(fmt_right, sample_in);

   // Reference and multiplexer switching; all open when disabled
   // The reserved positive code opens every positive reference switch, not a guess.
   wire [2:0] pref_d = !en ? ACR_SW_NONE :
      (pref == ACR_PREF_SUPPLY) ? ACR_SW_RAIL :
      (pref == ACR_PREF_EXT) ? ACR_SW_EXT :
      (pref == ACR_PREF_FIXED) ? ACR_SW_FIXED : ACR_SW_NONE;
   wire [1:0] nref_d = !en ? 2'h0 : (nref ? 2'h2 : 2'h1);

   // Read mux; unmapped addresses read zero
   // Each register sits in the low byte lane of its word.
   logic [7:0] rd_byte;
   always_comb begin
      unique case (rd_addr)
         ACR_OFS_CTRL: rd_byte = ctrl_q;
         ACR_OFS_CFG: rd_byte = cfg_q & ACR_CFG_WMASK;
         ACR_OFS_TRIG: rd_byte = trig_q & ACR_TRIG_WMASK;
         ACR_OFS_RESH: rd_byte = resh_q;
         ACR_OFS_RESL: rd_byte = resl_q;
         ACR_OFS_IRQ_STAT: rd_byte = irq_stat_q;
         ACR_OFS_IRQ_MASK: rd_byte = irq_mask_q;
         ACR_OFS_SAMPLE: rd_byte = sample_in[7:0];
         default: rd_byte = ACR_RST_BYTE;
      endcase
   end

   // ***************************************************************
   // Bus slave: zero wait states, always OKAY
   // ***************************************************************
   // A write keeps its address one cycle, as the data come in the
   // next cycle. A read is answered from its address phase, so hrdata
   // stands through the whole data phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= ACR_RST_BYTE;
         hrdata <= ACR_ZERO_WORD;
      end else begin
         wr_pend_q <= wr_req;
         wr_addr_q <= rd_addr;
         if (rd_req) begin
            hrdata <= {24'h000000, rd_byte};
         end
      end
   end

   // Configuration registers clear on every reset.
   // Masking at write time keeps unimplemented bits zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= ACR_RST_BYTE;
         trig_q <= ACR_RST_BYTE;
         irq_mask_q <= ACR_RST_BYTE;
      end else begin
         if (wr_cfg) cfg_q <= wbyte & ACR_CFG_WMASK;
         if (wr_trig) trig_q <= wbyte & ACR_TRIG_WMASK;
         if (wr_mask) irq_mask_q <= wbyte;
      end
   end

   // Control: enable plus status bit; hardware clear on completion,
   // software may also abort by writing zero. Disable aborts too.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= ACR_RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wbyte & ACR_CTRL_WMASK;
         end
         if (trig_start) begin
            ctrl_q[ACR_CTRL_GO_BIT] <= 1'b1;
         end else if (state_q == ACR_LOAD || (!en && !wr_ctrl)) begin
            // A status bit left up while disabled would hang a poll
            ctrl_q[ACR_CTRL_GO_BIT] <= 1'b0;
         end
      end
   end

   // Results have no reset: content survives a bus reset.
   // A load and a write in one cycle: the newer load wins.
   always_ff @(posedge hclk) begin
      if (state_q == ACR_LOAD) begin
         resh_q <= just[15:8];
         resl_q <= just[7:0];
      end else begin
         if (wr_resh) resh_q <= wbyte;
         if (wr_resl) resl_q <= wbyte;
      end
   end

   // Done flag: set wins over a write-one clear
   // so a conversion ending during the clear is never lost. Only bit 0
   // has a source; the other status bits stay zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_q <= ACR_RST_BYTE;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_stat ? wbyte : ACR_RST_BYTE)) |
            ((state_q == ACR_LOAD) ? 8'h01 : 8'h00);
      end
   end

   // ***************************************************************
   // Sequencer
   // ***************************************************************
   // Idle until a software or trigger start; run eleven conversion
   // clock periods; one load cycle writes both results and the flag
   // together, so software never sees a half-updated pair.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ACR_IDLE;
      end else begin
         unique case (state_q)
            ACR_IDLE: begin
               if (sw_go || trig_start) state_q <= ACR_CONV;
            end
            ACR_CONV: begin
               // Leave at the very write that drops enable or status,
               // so the hold never outlives the enable.
               if (!en || (wr_ctrl &&
                  !(wbyte[ACR_CTRL_GO_BIT] && wbyte[ACR_CTRL_EN_BIT]))) begin
                  state_q <= ACR_IDLE;
               end else if (conv_done) begin
                  state_q <= ACR_LOAD;
               end
            end
            ACR_LOAD: state_q <= ACR_IDLE;
            default: state_q <= ACR_IDLE;
         endcase
      end
   end

   // Divider and conversion-period counter; divider restarts per start
   // so the first period is whole.
   // The RC choice uses this counter at a fixed count, which is
   // exact only for the nominal oscillator rate.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= ACR_RST_BYTE;
         tad_cnt_q <= 4'h0;
      end else begin
         if (state_q != ACR_CONV || tad_tick) div_q <= ACR_RST_BYTE;
         else div_q <= div_q + 8'h01;
         if (state_q != ACR_CONV) tad_cnt_q <= 4'h0;
         else if (tad_tick) tad_cnt_q <= tad_cnt_q + 4'h1;
      end
   end

   // Trigger synchronisers: 3 stages, a rise counts when 2 and 3 agree, a fall on stage 2 alone
   // The first stage may go metastable, so nothing else reads it.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         trig_prev_q <= 1'b0;
      end else begin
         s1_q <= trig_src;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Previous agreed level; stage 2 high with stage 3 low keeps old value
         if (trig_lvl == trig_sel || !trig_lvl) trig_prev_q <= trig_sel;
      end
   end

   // ***************************************************************
   // Registered outputs
   // ***************************************************************
   // Every output is a flop: switches follow a write by one cycle and
   // the analog side never sees a decode glitch.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_clk_en <= 1'b0;
         rc_osc_en <= 1'b0;
         pref_switch <= ACR_SW_NONE;
         nref_switch <= 2'h0;
         chan_mux_en <= 1'b0;
         converter_enable <= 1'b0;
         sample_hold <= 1'b0;
         irq <= 1'b0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         conv_clk_en <= tad_tick && (state_q == ACR_CONV);
         rc_osc_en <= en && use_rc;
         pref_switch <= pref_d;
         nref_switch <= nref_d;
         chan_mux_en <= en;
         converter_enable <= en;
         sample_hold <= (state_q == ACR_CONV);
         irq <= |(irq_stat_q & irq_mask_q);
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Unused control bits are stored but drive nothing; go mirrors state
   // This sink only marks them as read on purpose.
   wire unused_ok = go ^ ^ctrl_q[7:2];

endmodule

// ===== inc/acr_pkg.sv
/*
 Package for the converter control and result block: register offsets,
 field positions, reset values, clock divider codes, trigger codes,
 reference selections and timing constants.
 Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
*/
package acr_pkg;

   // ***************************************************************
   // Register map (byte addresses)
   // ***************************************************************
   localparam logic [7:0] ACR_OFS_CTRL = 8'h00; // converter_control_main
   localparam logic [7:0] ACR_OFS_CFG = 8'h04; // converter_config
   localparam logic [7:0] ACR_OFS_TRIG = 8'h08; // auto_trigger_select
   localparam logic [7:0] ACR_OFS_RESH = 8'h0c; // result_high
   localparam logic [7:0] ACR_OFS_RESL = 8'h10; // result_low
   localparam logic [7:0] ACR_OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] ACR_OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] ACR_OFS_SAMPLE = 8'h1c; // sample input mirror

   // ***************************************************************
   // Field positions and masks
   // ***************************************************************
   localparam int ACR_CTRL_EN_BIT = 0;
   localparam int ACR_CTRL_GO_BIT = 1;
   localparam int ACR_CFG_FMT_BIT = 7;
   localparam int ACR_CFG_CS_LSB = 4;
   localparam int ACR_CFG_NREF_BIT = 2;
   localparam int ACR_CFG_PREF_LSB = 0;
   localparam logic [7:0] ACR_CFG_WMASK = 8'hf7;
   localparam logic [7:0] ACR_TRIG_WMASK = 8'h1f;
   localparam logic [7:0] ACR_CTRL_WMASK = 8'hff;
   localparam logic [7:0] ACR_RST_BYTE = 8'h00;
   localparam int ACR_IRQ_DONE_BIT = 0;
   localparam logic [31:0] ACR_ZERO_WORD = 32'h0000_0000;

   // ***************************************************************
   // Conversion clock select codes
   // ***************************************************************
   localparam logic [2:0] ACR_CS_DIV2 = 3'h0;
   localparam logic [2:0] ACR_CS_DIV8 = 3'h1;
   localparam logic [2:0] ACR_CS_DIV32 = 3'h2;
   localparam logic [2:0] ACR_CS_RC_A = 3'h3;
   localparam logic [2:0] ACR_CS_DIV4 = 3'h4;
   localparam logic [2:0] ACR_CS_DIV16 = 3'h5;
   localparam logic [2:0] ACR_CS_DIV64 = 3'h6;
   localparam logic [2:0] ACR_CS_RC_B = 3'h7;

   // ***************************************************************
   // Reference select codes
   // ***************************************************************
   localparam logic [1:0] ACR_PREF_SUPPLY = 2'h0;
   localparam logic [1:0] ACR_PREF_RSVD = 2'h1;
   localparam logic [1:0] ACR_PREF_EXT = 2'h2;
   localparam logic [1:0] ACR_PREF_FIXED = 2'h3;
   // One-hot reference switch encodings: bit0 ground/supply, 1 ext, 2 fixed
   localparam logic [2:0] ACR_SW_NONE = 3'h0;
   localparam logic [2:0] ACR_SW_RAIL = 3'h1;
   localparam logic [2:0] ACR_SW_EXT = 3'h2;
   localparam logic [2:0] ACR_SW_FIXED = 3'h4;

   // ***************************************************************
   // Auto-trigger codes; source vector index equals the code
   // ***************************************************************
   localparam logic [4:0] ACR_TRG_NONE = 5'h00;
   localparam logic [4:0] ACR_TRG_TMR4 = 5'h01;
   localparam logic [4:0] ACR_TRG_TMR6 = 5'h02;
   localparam logic [4:0] ACR_TRG_TMR0 = 5'h03;
   localparam logic [4:0] ACR_TRG_TMR1 = 5'h04;
   localparam logic [4:0] ACR_TRG_TMR2 = 5'h05;
   localparam logic [4:0] ACR_TRG_CMP1 = 5'h06;
   localparam logic [4:0] ACR_TRG_CMP2 = 5'h07;
   localparam logic [4:0] ACR_TRG_LC1 = 5'h08;
   localparam logic [4:0] ACR_TRG_CAP1 = 5'h0c;
   localparam logic [4:0] ACR_TRG_TMR3 = 5'h10;
   localparam logic [4:0] ACR_TRG_TMR5 = 5'h11;
   localparam int ACR_TRG_SRCS = 18;

   // ***************************************************************
   // Conversion timing
   // ***************************************************************
   localparam int ACR_RES_W = 10;
   localparam int ACR_CONV_TADS = 11; // conversion clock periods
   localparam int ACR_HCLK_MHZ = 250;
   // Dedicated RC period in ns, and its cycle count at hclk
   localparam int ACR_RC_PERIOD_NS = 1000;
   localparam int ACR_RC_CYCLES = (ACR_RC_PERIOD_NS * ACR_HCLK_MHZ) / 1000;
   localparam logic [7:0] ACR_RC_DIV = 8'(ACR_RC_CYCLES);

   typedef enum logic [1:0] {
      ACR_IDLE = 2'b00,
      ACR_CONV = 2'b01,
      ACR_LOAD = 2'b10
   } acr_state_e;

endpackage

// ===== tb/acr_checker.sv
/*
 Checker for the converter control and result block, bound to acr_top.
 Assumes one clock, hclk, and the asynchronous active-low reset hresetn.
*/
`timescale 1ns/1ns
module acr_checker
   import acr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic conv_clk_en,
   input wire logic rc_osc_en,
   input wire logic [2:0] pref_switch,
   input wire logic [1:0] nref_switch,
   input wire logic chan_mux_en,
   input wire logic converter_enable,
   input wire logic sample_hold
);
   // ***************************************************************
   // Properties
   // ***************************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // A started conversion holds for more than one cycle; a write abort
   // cannot land sooner than that
   sequence conv_run;
      sample_hold [*2];
   endsequence

   rdata_pad_a: assert property (hrdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   off_switch_a: assert property (!converter_enable |->
      pref_switch == 3'h0 && nref_switch == 2'h0 && !chan_mux_en)
      else $error("multiplexer input connected while disabled");
   nref_pick_a: assert property (converter_enable |->
      nref_switch == 2'h1 || nref_switch == 2'h2)
      else $error("negative reference not one of two choices");
   pref_hot_a: assert property ($onehot0(pref_switch))
      else $error("positive reference switches overlap");
   rc_gate_a: assert property (rc_osc_en |-> converter_enable)
      else $error("dedicated oscillator on while disabled");
   clk_gap_a: assert property (conv_clk_en |=> !conv_clk_en)
      else $error("conversion clock faster than half rate");
   conv_hold_a: assert property ($rose(sample_hold) |-> conv_run)
      else $error("conversion ended at once");
   conv_tick_a: assert property ($rose(sample_hold) |->
      ##[1:260] conv_clk_en)
      else $error("no conversion clock during conversion");
   hold_en_a: assert property (sample_hold |-> converter_enable)
      else $error("converting while disabled");
endmodule
bind acr_top acr_checker u_acr_checker (.hclk(hclk), .hresetn(hresetn),
   .hrdata(hrdata), .conv_clk_en(conv_clk_en), .rc_osc_en(rc_osc_en),
   .pref_switch(pref_switch), .nref_switch(nref_switch),
   .chan_mux_en(chan_mux_en), .converter_enable(converter_enable),
   .sample_hold(sample_hold));

// ===== tb/acr_trig_model.sv
/*
 Far-side model: trigger sources and the analog core's sample.
 Assumes the bench asks for one source at a time through fire.
*/
`timescale 1ns/1ns
module acr_trig_model
   import acr_pkg::*;
(
   input wire logic hclk,
   input wire logic fire,
   input wire logic [4:0] code,
   input wire logic [7:0] len,
   input wire logic [9:0] value,
   output logic [ACR_TRG_SRCS-1:0] trig_src,
   output logic [ACR_RES_W-1:0] sample_in
);
   logic [7:0] cnt_q = 8'h00;
   logic [ACR_TRG_SRCS-1:0] src_q = '0;

   // A source rises like a peripheral flag and stays up len+1 cycles, so
   // a level longer than a conversion can expose level sensitivity
   always @(posedge hclk) begin
      if (fire) begin
         src_q[code] <= 1'b1;
         cnt_q <= len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end else begin
         src_q <= '0;
      end
   end
   assign trig_src = src_q;
   assign sample_in = value; // Core sample, steady at load
endmodule

// ===== tb/tb_top.sv
/*
 Self-checking bench for acr_top: AHB-Lite master tasks, trigger model.
 Assumes zero-wait-state slave and results loaded at conversion end.
*/
`timescale 1ns/1ns
module tb_top
   import acr_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, fire;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [1:0] htrans, nref_switch;
   logic [2:0] hsize, pref_switch;
   logic [ACR_TRG_SRCS-1:0] trig_src;
   logic [ACR_RES_W-1:0] sample_in;
   logic conv_clk_en, rc_osc_en, chan_mux_en, converter_enable;
   logic sample_hold, irq;
   logic [4:0] tcode;
   logic [7:0] tlen;
   logic [9:0] tval;
   int fail_count, num_checks, cyc;
   int dtab [8] = '{2, 8, 32, ACR_RC_CYCLES, 4, 16, 64, ACR_RC_CYCLES};
   logic [2:0] ptab [4] = '{3'h1, 3'h0, 3'h2, 3'h4};
   logic [4:0] codes [13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h07, 5'h08, 5'h0b, 5'h0c, 5'h0f, 5'h10, 5'h11};

   acr_top u_acr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .trig_src(trig_src),
      .sample_in(sample_in), .conv_clk_en(conv_clk_en),
      .rc_osc_en(rc_osc_en), .pref_switch(pref_switch),
      .nref_switch(nref_switch), .chan_mux_en(chan_mux_en),
      .converter_enable(converter_enable), .sample_hold(sample_hold),
      .irq(irq));
   acr_trig_model u_acr_trig_model (.hclk(hclk), .fire(fire),
      .code(tcode), .len(tlen), .value(tval), .trig_src(trig_src),
      .sample_in(sample_in));

   // ***************************************************************
   // Tasks
   // ***************************************************************
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One single transfer; each phase held until hready is seen high
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdata = hrdata;
   endtask

   task rdc(input logic [7:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 8'h00);
      chk(rdata, {24'h000000, exp});
   endtask

   // Polling the flag, not go, also covers trigger starts that lag
   task conv_wait;
      int n;
      n = 0;
      rdata = '0;
      while (rdata[0] !== 1'b1 && n < 500) begin
         xfer(1'b0, ACR_OFS_IRQ_STAT, 8'h00);
         n++;
      end
   endtask

   task pulse(input logic [4:0] c, input logic [7:0] l);
      fire <= 1'b1;
      tcode <= c;
      tlen <= l;
      @(posedge hclk);
      fire <= 1'b0;
   endtask

   function automatic logic [7:0] ehi(input logic f, input logic [9:0] s);
      return f ? {6'h00, s[9:8]} : s[9:2];
   endfunction

   function automatic logic [7:0] elo(input logic f, input logic [9:0] s);
      return f ? s[7:0] : {s[1:0], 6'h00};
   endfunction

   // ***************************************************************
   // Clock, watchdog and tests
   // ***************************************************************
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   initial begin
      #200000;
      fail_count++;
      complete_run;
   end

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, fire, htrans, haddr, hwdata} = '0;
      {tcode, tlen, tval, fail_count, num_checks} = '0;
      hsize = 3'h2;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(ACR_OFS_CFG, 8'h00);
      rdc(ACR_OFS_TRIG, 8'h00);
      rdc(8'h40, 8'h00);
      chk(hresp, 0);
      xfer(1'b1, ACR_OFS_CFG, 8'hff);
      rdc(ACR_OFS_CFG, 8'hf7);
      xfer(1'b1, ACR_OFS_TRIG, 8'hff);
      rdc(ACR_OFS_TRIG, 8'h1f);
      xfer(1'b1, ACR_OFS_CTRL, 8'h01);
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, ACR_OFS_CFG, {1'b0, i[2:0], 1'b0, i[0], i[1:0]});
         repeat (2) @(posedge hclk);
         chk(converter_enable & chan_mux_en, 1);
         chk(rc_osc_en, i[1:0] == 2'h3);
         chk(nref_switch, i[0] ? 2'h2 : 2'h1);
         chk(pref_switch, ptab[i[1:0]]);
      end
      xfer(1'b1, ACR_OFS_CTRL, 8'h00);
      repeat (2) @(posedge hclk);
      chk({pref_switch, nref_switch, chan_mux_en, rc_osc_en}, 0);
      // Hold length per clock code: eleven periods of its ratio
      foreach (dtab[c]) begin
         xfer(1'b1, ACR_OFS_CFG, {1'b0, c[2:0], 4'h0});
         xfer(1'b1, ACR_OFS_CTRL, 8'h03);
         cyc = 0;
         repeat (2) @(posedge hclk);
         while (sample_hold === 1'b1 && cyc < 3000) begin
            cyc++;
            @(posedge hclk);
         end
         chk(cyc, ACR_CONV_TADS * dtab[c]);
      end
      xfer(1'b1, ACR_OFS_IRQ_STAT, 8'h01);
      for (int f = 0; f < 2; f++) begin
         xfer(1'b1, ACR_OFS_CTRL, 8'h01);
         xfer(1'b1, ACR_OFS_IRQ_MASK, f[7:0]);
         xfer(1'b1, ACR_OFS_CFG, {f[0], 7'h00});
         tval <= f[0] ? 10'h2b7 : 10'h1c9;
         xfer(1'b1, ACR_OFS_CTRL, 8'h03);
         conv_wait;
         chk(rdata[0], 1);
         rdc(ACR_OFS_CTRL, 8'h01);
         rdc(ACR_OFS_RESH, ehi(f[0], tval));
         rdc(ACR_OFS_RESL, elo(f[0], tval));
         chk(irq, f[0]);
         xfer(1'b1, ACR_OFS_IRQ_STAT, 8'h01);
         repeat (2) @(posedge hclk);
         chk(irq, 0);
      end
      foreach (codes[k]) begin
         xfer(1'b1, ACR_OFS_TRIG, {3'h0, codes[k]});
         tval <= {codes[k], codes[k]};
         pulse(codes[k] ^ 5'h01, 8'd10);
         repeat (40) @(posedge hclk);
         rdc(ACR_OFS_IRQ_STAT, 8'h00);
         pulse(codes[k], 8'd60);
         conv_wait;
         chk(rdata[0], 1);
         rdc(ACR_OFS_RESL, elo(1'b1, tval));
         xfer(1'b1, ACR_OFS_IRQ_STAT, 8'h01);
         repeat (60) @(posedge hclk);
         rdc(ACR_OFS_IRQ_STAT, 8'h00);
      end
      xfer(1'b1, ACR_OFS_TRIG, 8'h00);
      pulse(5'h01, 8'd10);
      @(posedge hclk);
      pulse(5'h11, 8'd10);
      repeat (40) @(posedge hclk);
      rdc(ACR_OFS_IRQ_STAT, 8'h00);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(ACR_OFS_CFG, 8'h00);
      rdc(ACR_OFS_RESL, elo(1'b1, tval));
      complete_run;
   end
endmodule
